// ---- logic/ctd_copro_transfer_decode.sv ----
// Purpose: Register and memory transfer decode and execute for a coprocessor.
// Assumes: The core offers one instruction at a time and retries if refused.
// Notes:   Arithmetic, conversion and accumulator operations are not here.
// Summary of operation
// [RL1] Decode core-to-coprocessor moves by number, opcode.
// [RL2] Decode coprocessor-to-core reads and compares.
// [RL3] Sixteen registers, any index field selects.
// [RL4] Immediate operands are seven bits wide.
// [RL5] Single load writes fetched single to register.
// [RL6] Double load writes fetched double to register.
// [RL7] Int32 load sign extends through bit 63.
// [RL8] Int64 load writes all 64 bits.
// [RL9] Single store supplies register's single value.
// [RL10] Double store supplies register's double value.
// [RL11] Int32 store supplies register's low word.
// [RL12] Int64 store supplies full 64 bits.
// [RL13] Single move writes bits 63 to 32.
// [RL14] Low double move writes bits 31 to 0.
// [RL15] High double move writes bits 63 to 32.
// [RL16] Low int64 move sign extends bit 31.
// [RL17] High int64 move writes bits 63 to 32.
// [RL18] Core-handled fields never influence decoding.
// [RL19] Software fills doubly ignored fields as documented.
// [RL20] Width bit selects 32 or 64 data.
// [RL21] Reads return high or low register half.
// [RL22] Empty opcode map entries are refused.
`timescale 1ns/100ps

module ctd_copro_transfer_decode (
  // Clock and reset.
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  // Instruction offer from the core.
  input  wire logic                      ins_valid,
  input  wire logic [31:0]               ins_word,
  output logic                           ins_accept,
  // Core register transfer.
  input  wire logic [ctd_pkg::DATA_W-1:0] core_wdata,
  output logic [ctd_pkg::DATA_W-1:0]     core_rdata,
  output logic                           core_rvalid,
  // Load data from memory.
  input  wire logic                      ld_valid,
  input  wire logic [ctd_pkg::DATA_W-1:0] ld_data,
  output logic                           ld_ready,
  // Store data to memory.
  output logic                           st_valid,
  output logic [ctd_pkg::DATA_W-1:0]     st_data,
  input  wire logic                      st_ready,
  // Status.
  output logic                           busy
);

  ctd_pkg::ctd_dec_t                dec;
  ctd_pkg::ctd_state_t              state;
  ctd_pkg::ctd_state_t              next_state;
  ctd_pkg::ctd_op_t                 op;
  ctd_pkg::ctd_op_t                 next_op;
  logic [3:0]                       dst;
  logic [3:0]                       next_dst;
  logic [1:0]                       cnt;
  logic [1:0]                       next_cnt;
  logic [ctd_pkg::REG_W-1:0]        regs      [ctd_pkg::NUM_REGS];
  logic [ctd_pkg::REG_W-1:0]        next_regs [ctd_pkg::NUM_REGS];
  logic [ctd_pkg::DATA_W-1:0]       next_rdata;
  logic                             next_rvalid;
  logic                             next_st_valid;
  logic [ctd_pkg::DATA_W-1:0]       next_st_data;
  logic [ctd_pkg::REG_W-1:0]        rd_a;
  logic [ctd_pkg::REG_W-1:0]        rd_b;

  // Decodes one instruction word; anything unrecognised comes back not ok.
  function automatic ctd_pkg::ctd_dec_t decode(input logic [31:0] w);
    ctd_pkg::ctd_dec_t d;
    logic [3:0]        cp;
    logic [2:0]        op2;
    logic              intg;
    d    = '0;
    d.op = ctd_pkg::OP_NONE;
    cp   = w[ctd_pkg::F_CP_LSB +: 4];
    op2  = w[ctd_pkg::F_OP2_LSB +: 3];
    intg = (cp == ctd_pkg::CP_INT);
    d.copro_dest_index   = w[ctd_pkg::F_CRD_LSB +: 4];
    d.copro_first_index  = w[ctd_pkg::F_CRN_LSB +: 4];
    d.copro_second_index = w[ctd_pkg::F_CRM_LSB +: 4];
    // [RL18] Only class, number, opcodes, width and direction are inspected.
    if (w[27:25] == ctd_pkg::CLS_MEM && (intg || cp == ctd_pkg::CP_FLT)) begin
      d.ok = 1'b1;
      // [RL20] Width bit picks the size.
      case ({intg, w[ctd_pkg::F_WIDE_BIT], w[ctd_pkg::F_LOAD_BIT]})
        3'b000:  d.op = ctd_pkg::ST_S;
        3'b001:  d.op = ctd_pkg::LD_S;
        3'b010:  d.op = ctd_pkg::ST_D;
        3'b011:  d.op = ctd_pkg::LD_D;
        3'b100:  d.op = ctd_pkg::ST_32;
        3'b101:  d.op = ctd_pkg::LD_32;
        3'b110:  d.op = ctd_pkg::ST_64;
        default: d.op = ctd_pkg::LD_64;
      endcase
    end else if (w[27:24] == ctd_pkg::CLS_RT && w[ctd_pkg::F_RT_BIT] &&
                 w[ctd_pkg::F_OP1_LSB +: 3] == ctd_pkg::OP1_XFER &&
                 (intg || cp == ctd_pkg::CP_FLT)) begin
      if (!w[ctd_pkg::F_LOAD_BIT]) begin
        // [RL1] Moves from the core.
        case ({intg, op2})
          {1'b0, ctd_pkg::OP2_LO}:  d.op = ctd_pkg::MV_DLO;
          {1'b0, ctd_pkg::OP2_HI}:  d.op = ctd_pkg::MV_DHI;
          {1'b0, ctd_pkg::OP2_SGL}: d.op = ctd_pkg::MV_SGL;
          {1'b1, ctd_pkg::OP2_LO}:  d.op = ctd_pkg::MV_64LO;
          {1'b1, ctd_pkg::OP2_HI}:  d.op = ctd_pkg::MV_64HI;
          default:                  d.op = ctd_pkg::OP_NONE;
        endcase
      end else begin
        // [RL2] Reads and compares toward the core.
        case ({intg, op2})
          {1'b0, ctd_pkg::OP2_LO}:   d.op = ctd_pkg::RD_DLO;
          {1'b0, ctd_pkg::OP2_HI}:   d.op = ctd_pkg::RD_DHI;
          {1'b0, ctd_pkg::OP2_SGL}:  d.op = ctd_pkg::RD_SGL;
          {1'b0, ctd_pkg::OP2_CMPN}: d.op = ctd_pkg::CMP_S;
          {1'b0, ctd_pkg::OP2_CMPW}: d.op = ctd_pkg::CMP_D;
          {1'b1, ctd_pkg::OP2_LO}:   d.op = ctd_pkg::RD_64LO;
          {1'b1, ctd_pkg::OP2_HI}:   d.op = ctd_pkg::RD_64HI;
          {1'b1, ctd_pkg::OP2_CMPN}: d.op = ctd_pkg::CMP_32;
          {1'b1, ctd_pkg::OP2_CMPW}: d.op = ctd_pkg::CMP_64;
          default:                   d.op = ctd_pkg::OP_NONE;
        endcase
      end
      // [RL22] Empty map slots stay refused.
      d.ok = (d.op != ctd_pkg::OP_NONE);
    end
    return d;
  endfunction

  // Compare flags N Z C V in the top nibble; V is never set because
  // unordered operands are not detected, a limitation of this block.
  function automatic logic [3:0] cmp_flags(input logic [63:0] a,
                                           input logic [63:0] b,
                                           input logic        flt,
                                           input logic        wide);
    logic [63:0] x;
    logic [63:0] y;
    logic        lt;
    logic        eq;
    x = a;
    y = b;
    if (!wide) begin
      x = flt ? {a[63:32], 32'h0000_0000} : {{32{a[31]}}, a[31:0]};
      y = flt ? {b[63:32], 32'h0000_0000} : {{32{b[31]}}, b[31:0]};
    end
    // Plus and minus zero compare equal in the float forms.
    eq = (x == y) || (flt && x[62:0] == '0 && y[62:0] == '0);
    if (!flt)
      lt = $signed(x) < $signed(y);
    else if (x[63] != y[63])
      lt = x[63] && !eq;
    else
      lt = x[63] ? (x[62:0] > y[62:0]) : (x[62:0] < y[62:0]);
    return {lt, eq, !lt, 1'b0};
  endfunction

  // Decode and handshakes; a multi-word transfer refuses new offers.
  always_comb begin
    dec        = decode(ins_word);
    ins_accept = ins_valid && dec.ok && (state == ctd_pkg::ST_IDLE);
    ld_ready   = (state == ctd_pkg::ST_LOAD);
    busy       = (state != ctd_pkg::ST_IDLE);
    // [RL3] Any index field reaches all sixteen registers.
    rd_a       = regs[dec.copro_first_index];
    rd_b       = regs[dec.copro_second_index];
  end

  // Next values of the transfer engine and the register file.
  always_comb begin
    next_regs     = regs;
    next_state    = state;
    next_op       = op;
    next_dst      = dst;
    next_cnt      = cnt;
    next_rdata    = core_rdata;
    next_rvalid   = 1'b0;
    next_st_valid = st_valid;
    next_st_data  = st_data;
    case (state)
      ctd_pkg::ST_IDLE: begin
        if (ins_accept) begin
          next_op  = dec.op;
          next_dst = dec.copro_dest_index;
          next_cnt = '0;
          case (dec.op)
            // [RL13] Single into upper half.
            ctd_pkg::MV_SGL:
              next_regs[dec.copro_first_index][63:32] = core_wdata;
            // [RL14] Low double half.
            ctd_pkg::MV_DLO:
              next_regs[dec.copro_first_index][31:0] = core_wdata;
            // [RL15] High double half.
            ctd_pkg::MV_DHI:
              next_regs[dec.copro_first_index][63:32] = core_wdata;
            // [RL16] Sign extended low half.
            ctd_pkg::MV_64LO:
              next_regs[dec.copro_first_index] =
                {{32{core_wdata[31]}}, core_wdata};
            // [RL17] High integer half.
            ctd_pkg::MV_64HI:
              next_regs[dec.copro_first_index][63:32] = core_wdata;
            // [RL21] Read back a half.
            ctd_pkg::RD_SGL, ctd_pkg::RD_DHI, ctd_pkg::RD_64HI: begin
              next_rdata  = rd_a[63:32];
              next_rvalid = 1'b1;
            end
            ctd_pkg::RD_DLO, ctd_pkg::RD_64LO: begin
              next_rdata  = rd_a[31:0];
              next_rvalid = 1'b1;
            end
            ctd_pkg::CMP_S, ctd_pkg::CMP_D,
            ctd_pkg::CMP_32, ctd_pkg::CMP_64: begin
              next_rdata  = {cmp_flags(rd_a, rd_b,
                               dec.op inside {ctd_pkg::CMP_S, ctd_pkg::CMP_D},
                               dec.op inside {ctd_pkg::CMP_D, ctd_pkg::CMP_64}),
                             28'h000_0000};
              next_rvalid = 1'b1;
            end
            ctd_pkg::LD_S, ctd_pkg::LD_D, ctd_pkg::LD_32, ctd_pkg::LD_64:
              next_state = ctd_pkg::ST_LOAD;
            // [RL9] Single store from upper half.
            ctd_pkg::ST_S: begin
              next_state    = ctd_pkg::ST_STORE;
              next_st_valid = 1'b1;
              next_st_data  = regs[dec.copro_dest_index][63:32];
            end
            // [RL10] [RL11] [RL12] Low word goes first.
            ctd_pkg::ST_D, ctd_pkg::ST_32, ctd_pkg::ST_64: begin
              next_state    = ctd_pkg::ST_STORE;
              next_st_valid = 1'b1;
              next_st_data  = regs[dec.copro_dest_index][31:0];
            end
            default: next_state = ctd_pkg::ST_IDLE;
          endcase
        end
      end
      ctd_pkg::ST_LOAD: begin
        if (ld_valid) begin
          next_cnt = cnt + 2'd1;
          case (op)
            // [RL5] Single lands in upper half.
            ctd_pkg::LD_S: begin
              next_regs[dst][63:32] = ld_data;
              next_state            = ctd_pkg::ST_IDLE;
            end
            // [RL7] Sign extend to bit 63.
            ctd_pkg::LD_32: begin
              next_regs[dst] = {{32{ld_data[31]}}, ld_data};
              next_state     = ctd_pkg::ST_IDLE;
            end
            // [RL6] [RL8] Low word then high word.
            default: begin
              if (cnt == '0) begin
                next_regs[dst][31:0] = ld_data;
              end else begin
                next_regs[dst][63:32] = ld_data;
                next_state            = ctd_pkg::ST_IDLE;
              end
            end
          endcase
        end
      end
      ctd_pkg::ST_STORE: begin
        if (st_ready) begin
          next_cnt = cnt + 2'd1;
          if ((op == ctd_pkg::ST_D || op == ctd_pkg::ST_64) &&
              cnt == '0) begin
            next_st_data = regs[dst][63:32];
          end else begin
            next_st_valid = 1'b0;
            next_state    = ctd_pkg::ST_IDLE;
          end
        end
      end
      default: next_state = ctd_pkg::ST_IDLE;
    endcase
  end

  // Registers only; the file clears to zero so reads are defined.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state       <= ctd_pkg::ST_IDLE;
      op          <= ctd_pkg::OP_NONE;
      dst         <= '0;
      cnt         <= '0;
      core_rdata  <= '0;
      core_rvalid <= 1'b0;
      st_valid    <= 1'b0;
      st_data     <= '0;
      for (int i = 0; i < ctd_pkg::NUM_REGS; i++) begin
        regs[i] <= '0;
      end
    end else begin
      state       <= next_state;
      op          <= next_op;
      dst         <= next_dst;
      cnt         <= next_cnt;
      core_rdata  <= next_rdata;
      core_rvalid <= next_rvalid;
      st_valid    <= next_st_valid;
      st_data     <= next_st_data;
      regs        <= next_regs;
    end
  end

endmodule

// ---- inc/ctd_pkg.sv ----
// Purpose: Shared types, field positions and decode for the transfer decoder.
// Assumes: Instruction words follow the coprocessor transfer formats.
// Notes:   Fields that the core handles are never looked at here.
package ctd_pkg;

  localparam int        DATA_W     = 32;
  localparam int        REG_W      = 64;
  localparam int        NUM_REGS   = 16;
  localparam int        IMM_W      = 7;
  // Field positions inside an instruction word.
  localparam int        F_CP_LSB   = 8;
  localparam int        F_OP2_LSB  = 5;
  localparam int        F_OP1_LSB  = 21;
  localparam int        F_CRN_LSB  = 16;
  localparam int        F_CRD_LSB  = 12;
  localparam int        F_CRM_LSB  = 0;
  localparam int        F_LOAD_BIT = 20;
  localparam int        F_WIDE_BIT = 22;
  localparam int        F_RT_BIT   = 4;
  // Class, coprocessor number, opcode and word count codes.
  localparam logic [2:0] CLS_MEM   = 3'h6;
  localparam logic [3:0] CLS_RT    = 4'hE;
  localparam logic [3:0] CP_FLT    = 4'h4;
  localparam logic [3:0] CP_INT    = 4'h5;
  localparam logic [2:0] OP1_XFER  = 3'h0;
  localparam logic [2:0] OP2_LO    = 3'h0;
  localparam logic [2:0] OP2_HI    = 3'h1;
  localparam logic [2:0] OP2_SGL   = 3'h2;
  localparam logic [2:0] OP2_CMPN  = 3'h4;
  localparam logic [2:0] OP2_CMPW  = 3'h5;
  localparam logic [1:0] WORDS_ONE = 2'h1;
  localparam logic [1:0] WORDS_TWO = 2'h2;

  typedef enum logic [4:0] {
    OP_NONE, MV_SGL, MV_DLO, MV_DHI, MV_64LO, MV_64HI,
    RD_SGL, RD_DLO, RD_DHI, RD_64LO, RD_64HI,
    CMP_S, CMP_D, CMP_32, CMP_64,
    LD_S, LD_D, LD_32, LD_64, ST_S, ST_D, ST_32, ST_64
  } ctd_op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOAD  = 2'b01,
    ST_STORE = 2'b10
  } ctd_state_t;

  typedef struct packed {
    logic       ok;
    ctd_op_t    op;
    logic [3:0] copro_dest_index;
    logic [3:0] copro_first_index;
    logic [3:0] copro_second_index;
  } ctd_dec_t;

  // [RL4] Seven-bit immediate field.
  // Immediate operand of the immediate forms, always seven bits wide.
  function automatic logic [IMM_W-1:0] imm_field(input logic [31:0] w);
    return {w[F_OP2_LSB +: 3], w[F_CRM_LSB +: 4]};
  endfunction

endpackage

// ---- sim/ctd_props.sv ----
// Purpose: Port timing checks for the transfer decoder.
// Assumes: One clock domain with an asynchronous active low reset.
// Notes:   Class decode is repeated here so that a decode slip shows.
`timescale 1ns/100ps
module ctd_props (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        arst_n,
  // Core side.
  input wire logic        ins_valid,
  input wire logic [31:0] ins_word,
  input wire logic        ins_accept,
  input wire logic [31:0] core_wdata,
  input wire logic [31:0] core_rdata,
  input wire logic        core_rvalid,
  // Memory side.
  input wire logic        ld_valid,
  input wire logic [31:0] ld_data,
  input wire logic        ld_ready,
  input wire logic        st_valid,
  input wire logic [31:0] st_data,
  input wire logic        st_ready,
  input wire logic        busy
);
  logic tk;
  logic rt;
  logic rd;
  logic mem;
  // Taken offers and their class, used as triggers and in the past-value checks.
  assign tk  = ins_valid && ins_accept;
  assign rt  = ins_word[27:24] == 4'hE && ins_word[4];
  assign rd  = rt && ins_word[20];
  assign mem = ins_word[27:25] == 3'h6;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_read_answers: assert property (tk && rd |=> core_rvalid ##1
    (core_rvalid == $past(tk && rd)))
    else $error("read not answered in one cycle");
  a_no_stray_answer: assert property (core_rvalid |-> $past(tk && rd))
    else $error("answer without a read");
  a_cp_number: assert property (tk |-> ins_word[11:8] inside {4'h4, 4'h5})
    else $error("foreign coprocessor number taken");
  a_op1_zero: assert property (tk && rt |-> ins_word[23:21] == 3'h0)
    else $error("nonzero primary op taken");
  a_move_slots: assert property (tk && rt && !ins_word[20] |->
    ins_word[7:5] < (ins_word[8] ? 3'h2 : 3'h3))
    else $error("empty move slot taken");
  a_read_slots: assert property (tk && rd |-> ins_word[7:5] != 3'h3 &&
    ins_word[7:5] < 3'h6 && !(ins_word[8] && ins_word[7:5] == 3'h2))
    else $error("empty read slot taken");
  a_idle_accept: assert property (ins_accept |-> ins_valid && !busy)
    else $error("offer taken while busy");
  a_load_opens: assert property (tk && mem && ins_word[20] |=> ld_ready && busy)
    else $error("load did not open");
  a_store_opens: assert property (tk && mem && !ins_word[20] |=> st_valid)
    else $error("store did not open");
  a_store_holds: assert property (st_valid && !st_ready |=>
    st_valid && $stable(st_data))
    else $error("store word dropped");
  a_cmp_flags: assert property (core_rvalid && $past(ins_word[7]) |->
    core_rdata[28:0] == 29'h0)
    else $error("compare result has stray bits");
  a_single_store: assert property (tk && mem && !ins_word[20] && !ins_word[22]
    ##1 st_valid && st_ready |=> !st_valid)
    else $error("narrow store sent twice");
endmodule

// ---- sim/ctd_mem_model.sv ----
// Purpose: Memory side stand-in for the load and store channels.
// Assumes: A word passes on an edge where valid and ready are both high.
// Notes:   Stall idles every other cycle so that held requests are seen.
`timescale 1ns/100ps
module ctd_mem_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Bench controls and load words.
  input  wire logic        stall,
  input  wire logic [31:0] lw0,
  input  wire logic [31:0] lw1,
  // Load channel.
  output logic             ld_valid,
  output logic [31:0]      ld_data,
  input  wire logic        ld_ready,
  // Store channel.
  input  wire logic        st_valid,
  input  wire logic [31:0] st_data,
  output logic             st_ready
);
  logic        ph;
  logic        idx;
  logic [31:0] st_words [0:1];
  int          st_cnt;
  // Idle load data is inverted so a stale word is never taken as good.
  assign ld_valid = ld_ready && !(stall && ph);
  assign ld_data  = ld_valid ? (idx ? lw1 : lw0) : ~lw0;
  assign st_ready = !(stall && ph);
  // Phase, load word index and captured store words.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph     <= 1'h0;
      idx    <= 1'h0;
      st_cnt <= 0;
    end else begin
      ph  <= ~ph;
      idx <= ld_ready && (idx ^ ld_valid);
      if (st_valid && st_ready) begin
        st_words[st_cnt % 2] <= st_data;
        st_cnt               <= st_cnt + 1;
      end
    end
  end
endmodule

// ---- sim/ctd_copro_transfer_decode_bench.sv ----
// Purpose: Self-checking bench for the transfer decoder.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Expected values come from field layouts, never from outputs.
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  fail_count++; $display("FAIL %s exp %h got %h", n, e, g); end end
module ctd_copro_transfer_decode_bench;
  logic        clk, arst_n, ins_valid, ins_accept, core_rvalid, busy, stall;
  logic        ld_valid, ld_ready, st_valid, st_ready;
  logic [31:0] ins_word, core_wdata, core_rdata, ld_data, st_data;
  logic [31:0] lw0, lw1, rv;
  int          fail_count, samples_checked;
  ctd_copro_transfer_decode u_ctd_copro_transfer_decode (.clk(clk),
    .arst_n(arst_n), .ins_valid(ins_valid), .ins_word(ins_word),
    .ins_accept(ins_accept), .core_wdata(core_wdata),
    .core_rdata(core_rdata), .core_rvalid(core_rvalid),
    .ld_valid(ld_valid), .ld_data(ld_data), .ld_ready(ld_ready),
    .st_valid(st_valid), .st_data(st_data), .st_ready(st_ready),
    .busy(busy));
  ctd_mem_model u_ctd_mem_model (.clk(clk), .arst_n(arst_n), .stall(stall),
    .lw0(lw0), .lw1(lw1), .ld_valid(ld_valid), .ld_data(ld_data),
    .ld_ready(ld_ready), .st_valid(st_valid), .st_data(st_data),
    .st_ready(st_ready));
  // fixed fields
  // Ignored fields carry their set values: condition always, zero offset.
  function automatic logic [31:0] rtw(logic l, logic [3:0] c, logic [2:0] o,
                                      logic [3:0] n, logic [3:0] m);
    return {8'hEE, 3'h0, l, n, 4'h0, c, o, 1'h1, m};
  endfunction
  function automatic logic [31:0] mw(logic l, logic w, logic [3:0] c,
                                     logic [3:0] d);
    return {4'hE, 3'h6, 2'h3, w, 1'h0, l, 4'h0, d, c, 8'h00};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One offer for one edge; valid stays up so calls run back to back.
  task automatic issue(input logic [31:0] w, d, input logic acc);
    ins_valid  = 1'h1;
    ins_word   = w;
    core_wdata = d;
    #1;
    `CHK("accept", acc, ins_accept)
    @(negedge clk);
    `CHK("rvalid", acc & w[20] & w[4] & (w[27:24] == 4'hE), core_rvalid)
    rv = core_rdata;
  endtask
  task automatic rd(input logic [3:0] c, input logic [2:0] o,
                    input logic [3:0] i, input logic [31:0] e);
    issue(rtw(1'h1, c, o, i, 4'h0), 32'h0, 1'h1);
    `CHK("read", e, rv)
  endtask
  task automatic set_reg(input logic [3:0] i, input logic [31:0] lo, hi);
    issue(rtw(1'h0, 4'h4, 3'h0, i, 4'h0), lo, 1'h1);
    issue(rtw(1'h0, 4'h4, 3'h1, i, 4'h0), hi, 1'h1);
  endtask
  // Bounded wait for idle; a hang counts as a mismatch and ends the run.
  // The offer is withdrawn first so it is not taken once the block frees.
  task automatic wait_idle();
    int k;
    ins_valid = 1'h0;
    @(negedge clk);
    for (k = 0; k < 20 && busy !== 1'h0; k++)
      @(negedge clk);
    if (k == 20) begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  task automatic t_moves();
    logic [31:0] lo;
    rd(4'h4, 3'h1, 4'h0, 32'h0);
    for (int i = 0; i < 16; i++) begin
      lo = 32'h0101_0101 * i;
      set_reg(i[3:0], lo, ~lo);
      rd(4'h4, 3'h0, i[3:0], lo);
      rd(4'h5, 3'h1, i[3:0], ~lo);
      issue(rtw(1'h0, 4'h4, 3'h2, i[3:0], 4'h0), 32'h1234_5678, 1'h1);
      rd(4'h4, 3'h2, i[3:0], 32'h1234_5678);
      rd(4'h5, 3'h0, i[3:0], lo);
    end
    issue(rtw(1'h0, 4'h5, 3'h0, 4'h9, 4'h0), 32'h8000_00F0, 1'h1);
    rd(4'h4, 3'h1, 4'h9, 32'hFFFF_FFFF);
    issue(rtw(1'h0, 4'h5, 3'h1, 4'h9, 4'h0), 32'h0000_0042, 1'h1);
    rd(4'h4, 3'h1, 4'h9, 32'h0000_0042);
  endtask
  task automatic t_codes();
    logic a;
    for (int k = 0; k < 48; k++) begin
      a = k < 32 && (k[4] ? k[2:0] != 3 && k[2:0] < 6 &&
          !(k[3] && k[2:0] == 2) : k[2:0] < (k[3] ? 2 : 3));
      issue(rtw(k[4], k < 32 ? {3'h2, k[3]} : 4'h6, k[2:0], 4'hA, 4'h0) |
            (k[0] ? 32'h0020_0000 & {32{k[5]}} : 32'h0), 32'h0, a);
    end
  endtask
  task automatic t_compare();
    logic [3:0] c;
    mv_pair: begin
      issue(rtw(1'h0, 4'h5, 3'h0, 4'h1, 4'h0), 32'h5, 1'h1);
      issue(rtw(1'h0, 4'h5, 3'h0, 4'h2, 4'h0), 32'h9, 1'h1);
    end
    for (int k = 0; k < 4; k++) begin
      c = k[1] ? 4'h5 : 4'h4;
      issue(rtw(1'h1, c, {2'h2, k[0]}, 4'h1, 4'h2), 32'h0, 1'h1);
      `CHK("less", k == 0 ? 32'h6000_0000 : 32'h8000_0000, rv)
      issue(rtw(1'h1, c, {2'h2, k[0]}, 4'h2, 4'h1), 32'h0, 1'h1);
      `CHK("more", k == 0 ? 32'h6000_0000 : 32'h2000_0000, rv)
    end
  endtask
  task automatic t_loads();
    stall = 1'h1;
    for (int k = 0; k < 4; k++) begin
      set_reg(4'h3, 32'h1111_1111, 32'h2222_2222);
      lw0 = 32'h8765_4300 + k;
      issue(mw(1'h1, k[0], {3'h2, k[1]}, 4'h3) | 32'h002F_00FF,
            32'h0, 1'h1);
      issue(rtw(1'h1, 4'h4, 3'h0, 4'h3, 4'h0), 32'h0, 1'h0);
      wait_idle();
      rd(4'h4, 3'h0, 4'h3, k == 0 ? 32'h1111_1111 : lw0);
      rd(4'h4, 3'h1, 4'h3, k == 0 ? lw0 : k == 2 ? 32'hFFFF_FFFF : lw1);
    end
  endtask
  task automatic t_stores();
    int b;
    set_reg(4'h7, 32'h3333_0001, 32'h4444_0002);
    for (int k = 0; k < 4; k++) begin
      stall = k[0];
      b = u_ctd_mem_model.st_cnt;
      issue(mw(1'h0, k[0], {3'h2, k[1]}, 4'h7), 32'h0, 1'h1);
      wait_idle();
      `CHK("count", b + 1 + k[0], u_ctd_mem_model.st_cnt)
      `CHK("word0", k == 0 ? 32'h4444_0002 : 32'h3333_0001,
           u_ctd_mem_model.st_words[b % 2])
      if (k[0])
        `CHK("word1", 32'h4444_0002, u_ctd_mem_model.st_words[(b + 1) % 2])
    end
  endtask
  // Free-running clock.
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Reset, then each scenario in turn.
  initial begin
    {arst_n, ins_valid, stall, ins_word, core_wdata} = '0;
    lw0 = 32'h0;
    lw1 = 32'h0BAD_F00D;
    repeat (10) @(negedge clk);
    arst_n = 1'h1;
    t_moves();
    t_codes();
    t_compare();
    t_loads();
    t_stores();
    tally_and_finish();
  end
endmodule
bind ctd_copro_transfer_decode ctd_props u_props (.clk(clk), .arst_n(arst_n),
  .ins_valid(ins_valid), .ins_word(ins_word), .ins_accept(ins_accept),
  .core_wdata(core_wdata), .core_rdata(core_rdata),
  .core_rvalid(core_rvalid), .ld_valid(ld_valid), .ld_data(ld_data),
  .ld_ready(ld_ready), .st_valid(st_valid), .st_data(st_data),
  .st_ready(st_ready), .busy(busy));
